// ===== src/wfd_detector.sv
// wfd_detector: receive-side wake frame detector, top level.
// Assumes a byte stream from the receive path of any line speed, with a
// start pulse before each frame and an end pulse carrying the CRC result.
//
// What this block does
// RULE1 - wake notified by status, gpio, or flag
// RULE2 - detects magic, magic with password, pattern
// RULE3 - gpio pulse or level; else interrupt flag (here the flag has its own irq_enable and can fire together with the gpio)
// RULE4 - bad CRC frames never cause a wake
// RULE5 - works at every line speed
// RULE6 - pattern match over 64 programmable bytes
// RULE7 - magic search only on frames for us
// RULE8 - destination own or broadcast, CRC good
// RULE9 - sixteen unbroken repeats of station address
// RULE10 - password bytes must directly follow repeats
// RULE11 - sequence anywhere after a sync stream
// RULE12 - sync stream is six bytes of ones
// RULE13 - config inputs, status and interrupt outputs
// RULE14 - password six bytes from programmable storage
// RULE15 - broken match restarts search at current byte
`timescale 1ns/10ps
`default_nettype none
module wfd_detector
    import wfd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    // receive byte stream
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_eof,
    input wire logic rx_crc_ok,
    // wake receive config
    input wire logic magic_enable,
    input wire logic password_enable,
    input wire logic pattern_enable,
    input wire logic [47:0] station_addr,
    input wire logic [47:0] password,
    input wire logic [8*PATTERN_BYTES-1:0] pattern,
    input wire logic [PATTERN_BYTES-1:0] pattern_mask,
    input wire logic gpio_enable,
    input wire logic gpio_pulse_mode,
    input wire logic [GPIO_SEL_W-1:0] gpio_select,
    input wire logic irq_enable,
    // clears from the controller
    input wire logic status_clear,
    input wire logic irq_clear,
    // notification
    output logic [ST_BITS-1:0] wake_receive_status,
    output logic wake_irq,
    output logic [GPIO_PINS-1:0] wake_gpio
);

    logic in_frame;
    logic [6:0] pos;
    logic da_own;
    logic da_bcast;
    logic pattern_ok;
    logic magic_found;
    logic [7:0] pat_byte;
    logic frame_end;
    logic magic_hit;
    logic pattern_hit;
    logic [ST_BITS-1:0] wake_set;
    logic wake_any;
    logic [3:0] pulse_cnt;
    logic gpio_active;

    // ========================================================
    // magic sequence search; byte strobes make it speed neutral
    wfd_magic_match u_magic (
        .clk(clk),
        .reset(reset),
        .frame_start(rx_sof),
        .byte_valid(rx_valid && in_frame), // [RULE5]
        .byte_data(rx_data),
        .station_addr(station_addr),
        .password(password),
        .password_enable(password_enable),
        .found(magic_found)
    );

    // ========================================================
    // frame tracking; byte position saturates past the pattern
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_frame <= 1'b0;
            pos <= 7'h00;
        end else if (rx_sof) begin
            in_frame <= 1'b1;
            pos <= 7'h00;
        end else if (rx_eof) begin
            in_frame <= 1'b0;
        end else if (rx_valid && in_frame && pos != POS_PAT_END) begin
            pos <= pos + 7'h01;
        end
    end

    // ========================================================
    // destination address check over the first six bytes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            da_own <= 1'b0;
            da_bcast <= 1'b0;
        end else if (rx_sof) begin
            da_own <= 1'b1;
            da_bcast <= 1'b1;
        end else if (rx_valid && in_frame && pos < POS_DA_END) begin
            if (rx_data != wfd_addr_byte(station_addr, pos[2:0])) begin
                da_own <= 1'b0; // [RULE8]
            end
            if (rx_data != wfd_addr_byte(BCAST_ADDR, pos[2:0])) begin
                da_bcast <= 1'b0; // [RULE8]
            end
        end
    end

    // ========================================================
    // custom pattern compare; masked-off bytes are don't care
    assign pat_byte = pattern[8 * int'(pos[5:0]) +: 8];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pattern_ok <= 1'b0;
        end else if (rx_sof) begin
            pattern_ok <= 1'b1;
        end else if (rx_valid && in_frame && pos < POS_PAT_END) begin
            if (pattern_mask[pos[5:0]] && rx_data != pat_byte) begin
                pattern_ok <= 1'b0; // [RULE6]
            end
        end
    end

    // ========================================================
    // end-of-frame qualification; the CRC gate covers every type
    assign frame_end = rx_eof && in_frame && rx_crc_ok; // [RULE4]
    // the magic verdict only counts on frames addressed to us
    assign magic_hit = magic_enable && magic_found
        && (da_own || da_bcast); // [RULE7] [RULE8]
    // a short frame cannot have matched all 64 bytes
    assign pattern_hit = pattern_enable && pattern_ok
        && pos == POS_PAT_END; // [RULE6]

    always_comb begin
        wake_set = '0;
        if (frame_end) begin
            wake_set[ST_MAGIC] = magic_hit && !password_enable; // [RULE2]
            wake_set[ST_MAGIC_PW] = magic_hit && password_enable; // [RULE2]
            wake_set[ST_PATTERN] = pattern_hit; // [RULE2]
        end
    end

    assign wake_any = |wake_set;

    // ========================================================
    // sticky status; a new wake beats a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_receive_status <= '0;
        end else begin
            wake_receive_status <= wake_set
                | (status_clear ? '0 : wake_receive_status); // [RULE13]
        end
    end

    // ========================================================
    // interrupt flag; set wins over clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_irq <= 1'b0;
        end else if (wake_any && irq_enable) begin
            wake_irq <= 1'b1; // [RULE1] [RULE3]
        end else if (irq_clear) begin
            wake_irq <= 1'b0;
        end
    end

    // ========================================================
    // gpio event: fixed-width pulse, or a level held until status clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_cnt <= 4'h0;
            gpio_active <= 1'b0;
        end else if (wake_any && gpio_enable) begin
            pulse_cnt <= PULSE_CYCLES; // [RULE3]
            gpio_active <= 1'b1; // [RULE1]
        end else if (gpio_pulse_mode) begin
            if (pulse_cnt == 4'h1) begin
                gpio_active <= 1'b0; // [RULE3]
            end
            if (pulse_cnt != 4'h0) begin
                pulse_cnt <= pulse_cnt - 4'h1;
            end
        end else if (status_clear) begin
            gpio_active <= 1'b0; // [RULE3]
            pulse_cnt <= 4'h0;
        end
    end

    // route the event to the chosen pin only; others stay low
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_gpio <= '0;
        end else begin
            wake_gpio <= '0;
            wake_gpio[gpio_select] <= gpio_active; // [RULE3]
        end
    end

endmodule // wfd_detector
`default_nettype wire

// ===== src/wfd_pkg.sv
// wfd_pkg: constants and helpers shared by the wake frame detector files.
// Assumes a byte-wide receive stream; pure definitions, no logic.
package wfd_pkg;

    // ========================================================
    // frame layout
    localparam int SYNC_BYTES = 6;
    localparam logic [7:0] SYNC_VALUE = 8'hFF;
    localparam int ADDR_BYTES = 6;
    localparam int ADDR_REPS = 16;
    localparam int PASS_BYTES = 6;
    localparam int PATTERN_BYTES = 64;
    localparam logic [47:0] BCAST_ADDR = 48'hFFFF_FFFF_FFFF;

    // ========================================================
    // counter limits at counter width
    localparam logic [2:0] SYNC_FULL = 3'(SYNC_BYTES);
    localparam logic [2:0] ADDR_LAST = 3'(ADDR_BYTES - 1);
    localparam logic [4:0] REPS_LAST = 5'(ADDR_REPS - 1);
    localparam logic [2:0] PASS_LAST = 3'(PASS_BYTES - 1);
    localparam logic [6:0] POS_DA_END = 7'(ADDR_BYTES);
    localparam logic [6:0] POS_PAT_END = 7'(PATTERN_BYTES);

    // ========================================================
    // status bit positions and notification
    localparam int ST_MAGIC = 0;
    localparam int ST_MAGIC_PW = 1;
    localparam int ST_PATTERN = 2;
    localparam int ST_BITS = 3;
    localparam int GPIO_PINS = 4;
    localparam int GPIO_SEL_W = 2;
    // pulse width on the gpio, in clock cycles of 100 ns
    localparam int PULSE_NS = 800;
    localparam int CLK_NS = 100;
    localparam logic [3:0] PULSE_CYCLES = 4'(PULSE_NS / CLK_NS);

    // byte idx of a 48-bit address, first byte on the wire at the top
    function automatic logic [7:0] wfd_addr_byte(input logic [47:0] a,
                                                 input logic [2:0] idx);
        logic [5:0] sh;
        sh = 6'(40 - 8 * int'(idx));
        return 8'(a >> sh);
    endfunction

endpackage : wfd_pkg

// ===== src/wfd_magic_match.sv
// wfd_magic_match: scans one frame's bytes for the sync stream, the 16
// address repeats and the optional password. Assumes frame_start is a
// pulse in its own cycle before the first byte of every frame.
`timescale 1ns/10ps
`default_nettype none
module wfd_magic_match
    import wfd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic frame_start,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic [47:0] station_addr,
    input wire logic [47:0] password,
    input wire logic password_enable,
    output logic found
);

    typedef enum {WFD_SYNC, WFD_ADDR, WFD_PASS} wfd_state_t;

    wfd_state_t state;
    logic [2:0] sync_cnt;
    logic [2:0] byte_idx;
    logic [4:0] rep_cnt;
    logic is_sync;
    logic addr_hit;
    logic pass_hit;

    // ========================================================
    // byte compares
    assign is_sync = (byte_data == SYNC_VALUE);
    assign addr_hit = (byte_data == wfd_addr_byte(station_addr, byte_idx));
    assign pass_hit = (byte_data == wfd_addr_byte(password, byte_idx));

    // ========================================================
    // sequence search; a break restarts at the current byte
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= WFD_SYNC;
            sync_cnt <= 3'h0;
            byte_idx <= 3'h0;
            rep_cnt <= 5'h00;
            found <= 1'b0;
        end else if (frame_start) begin
            state <= WFD_SYNC;
            sync_cnt <= 3'h0;
            byte_idx <= 3'h0;
            rep_cnt <= 5'h00;
            found <= 1'b0;
        end else if (byte_valid && !found) begin
            case (state)
                WFD_SYNC: begin
                    if (sync_cnt == SYNC_FULL && addr_hit) begin
                        state <= WFD_ADDR; // [RULE11]
                        byte_idx <= 3'h1;
                        rep_cnt <= 5'h00;
                    end else if (is_sync) begin
                        // extra ones keep the stream armed
                        if (sync_cnt != SYNC_FULL) begin
                            sync_cnt <= sync_cnt + 3'h1; // [RULE12]
                        end
                    end else begin
                        sync_cnt <= 3'h0;
                    end
                end
                WFD_ADDR: begin
                    if (!addr_hit) begin
                        // idx back to the first byte, or the next try is skewed
                        state <= WFD_SYNC; // [RULE9] [RULE15]
                        sync_cnt <= is_sync ? 3'h1 : 3'h0;
                        byte_idx <= 3'h0;
                    end else if (byte_idx != ADDR_LAST) begin
                        byte_idx <= byte_idx + 3'h1;
                    end else begin
                        byte_idx <= 3'h0;
                        rep_cnt <= rep_cnt + 5'h01;
                        if (rep_cnt == REPS_LAST) begin
                            if (password_enable) begin
                                state <= WFD_PASS; // [RULE10]
                            end else begin
                                found <= 1'b1; // [RULE9]
                            end
                        end
                    end
                end
                WFD_PASS: begin
                    if (!pass_hit) begin
                        state <= WFD_SYNC; // [RULE10] [RULE15]
                        sync_cnt <= is_sync ? 3'h1 : 3'h0;
                        byte_idx <= 3'h0;
                    end else if (byte_idx == PASS_LAST) begin
                        found <= 1'b1; // [RULE14]
                    end else begin
                        byte_idx <= byte_idx + 3'h1;
                    end
                end
                default: begin
                    state <= WFD_SYNC;
                    sync_cnt <= 3'h0;
                end
            endcase
        end
    end

endmodule // wfd_magic_match
`default_nettype wire

// ===== tb/wfd_detector_monitor.sv
// wfd_detector_monitor: port-level assertions for the wake detector.
// Assumes one clock domain; bound to every wfd_detector instance.
`timescale 1ns/10ps
`default_nettype none
module wfd_detector_monitor
    import wfd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_eof,
    input wire logic rx_crc_ok,
    input wire logic gpio_enable,
    input wire logic gpio_pulse_mode,
    input wire logic irq_enable,
    input wire logic status_clear,
    input wire logic irq_clear,
    input wire logic [ST_BITS-1:0] wake_receive_status,
    input wire logic wake_irq,
    input wire logic [GPIO_PINS-1:0] wake_gpio
);
    // ========================================================
    // assertions, all on the rising clock edge
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire logic good = rx_eof && rx_crc_ok;
    wire logic gp = |wake_gpio;
    // a bad frame end must leave the status untouched
    bad_crc_a: assert property (
        rx_eof && !rx_crc_ok && !status_clear |=>
        $stable(wake_receive_status)) else $error("status moved on bad crc");
    status_source_a: assert property (|(wake_receive_status &
        ~$past(wake_receive_status)) |-> $past(good))
        else $error("status set without good frame end");
    irq_source_a: assert property ($rose(wake_irq) |->
        $past(good) && $past(irq_enable)) else $error("flag set without cause");
    irq_sticky_a: assert property (
        wake_irq && !irq_clear |=> wake_irq)
        else $error("flag dropped without clear");
    status_hold_a: assert property (!$past(status_clear) |->
        (~wake_receive_status & $past(wake_receive_status)) == 3'h0)
        else $error("status bit lost without clear");
    status_clear_a: assert property (status_clear && !rx_eof |=>
        wake_receive_status == 3'h0) else $error("status not cleared");
    gpio_pin_a: assert property ($onehot0(wake_gpio))
        else $error("more than one gpio high");
    gpio_rise_a: assert property ($rose(gp) |-> $past(good, 2))
        else $error("gpio rose without frame end");
    gpio_pulse_a: assert property (
        $rose(gp) && gpio_pulse_mode |-> gp [*8] ##1 !gp)
        else $error("gpio pulse width wrong");
    // the pin lags the clear by one cycle, so that cycle may still drop it
    gpio_level_a: assert property (
        !gpio_pulse_mode && gpio_enable && gp && !status_clear
        && !$past(status_clear) |=> gp) else $error("gpio level dropped");
endmodule // wfd_detector_monitor
bind wfd_detector wfd_detector_monitor mon (.clk(clk), .reset(reset),
    .rx_eof(rx_eof), .rx_crc_ok(rx_crc_ok), .gpio_enable(gpio_enable),
    .gpio_pulse_mode(gpio_pulse_mode), .irq_enable(irq_enable),
    .status_clear(status_clear), .irq_clear(irq_clear),
    .wake_receive_status(wake_receive_status), .wake_irq(wake_irq),
    .wake_gpio(wake_gpio));
`default_nettype wire

// ===== tb/wfd_host_model.sv
// wfd_host_model: the controller waiting for a wake indication.
// Assumes the detector's notification outputs on the same clock.
`timescale 1ns/10ps
`default_nettype none
module wfd_host_model
    import wfd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [GPIO_PINS-1:0] wake_gpio,
    input wire logic wake_irq,
    input wire logic auto_ack,
    output logic irq_clear,
    output logic [7:0] pulse_len,
    output logic [7:0] irq_seen
);
    logic [7:0] run;
    logic irq_last;
    // ========================================================
    // measure each gpio pulse so the bench can judge its width
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run <= 8'h00;
            pulse_len <= 8'h00;
        end else if (|wake_gpio) begin
            run <= run + 8'h01;
        end else if (run != 8'h00) begin
            pulse_len <= run;
            run <= 8'h00;
        end
    end
    // count flags and ack them one cycle late, as a slow driver would
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_clear <= 1'b0;
            irq_seen <= 8'h00;
            irq_last <= 1'b0;
        end else begin
            irq_last <= wake_irq;
            irq_clear <= auto_ack && wake_irq && !irq_clear;
            if (wake_irq && !irq_last) irq_seen <= irq_seen + 8'h01;
        end
    end
endmodule // wfd_host_model
`default_nettype wire

// ===== tb/test_wfd_detector.sv
// test_wfd_detector: self-checking bench for the wake frame detector.
// Assumes a 10 MHz clock and the host model as the far side.
`timescale 1ns/10ps
`default_nettype none
module test_wfd_detector;
    import wfd_pkg::*;
    logic clk = 0, reset = 1, rx_sof = 0, rx_valid = 0, rx_eof = 0;
    logic rx_crc_ok = 0, magic_enable = 1, password_enable = 0;
    logic pattern_enable = 0, gpio_enable = 1, gpio_pulse_mode = 1;
    logic irq_enable = 1, status_clear = 0, auto_ack = 1;
    logic [7:0] rx_data = 8'h00;
    logic [47:0] station_addr = 48'h1122_3344_5566;
    logic [47:0] password = 48'h2A2B_2C2D_2E2F;
    logic [8*PATTERN_BYTES-1:0] pattern = '0;
    logic [PATTERN_BYTES-1:0] pattern_mask = '0;
    logic [GPIO_SEL_W-1:0] gpio_select = 2'h2;
    logic irq_clear, wake_irq;
    logic [ST_BITS-1:0] wake_receive_status;
    logic [GPIO_PINS-1:0] wake_gpio;
    logic [7:0] pulse_len, irq_seen;
    logic [7:0] q[$];
    int err_count = 0, comparisons = 0, cycles = 0;
    // ========================================================
    // clock, design and far side
    always #50 clk = ~clk;
    wfd_detector DUT (.clk(clk), .reset(reset), .rx_sof(rx_sof),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_eof(rx_eof),
        .rx_crc_ok(rx_crc_ok), .magic_enable(magic_enable),
        .password_enable(password_enable), .pattern_enable(pattern_enable),
        .station_addr(station_addr), .password(password), .pattern(pattern),
        .pattern_mask(pattern_mask), .gpio_enable(gpio_enable),
        .gpio_pulse_mode(gpio_pulse_mode), .gpio_select(gpio_select),
        .irq_enable(irq_enable), .status_clear(status_clear),
        .irq_clear(irq_clear), .wake_receive_status(wake_receive_status),
        .wake_irq(wake_irq), .wake_gpio(wake_gpio));
    wfd_host_model host (.clk(clk), .reset(reset), .wake_gpio(wake_gpio),
        .wake_irq(wake_irq), .auto_ack(auto_ack), .irq_clear(irq_clear),
        .pulse_len(pulse_len), .irq_seen(irq_seen));
    // ========================================================
    // helpers
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic add(input logic [47:0] a);
        for (int i = 0; i < 6; i++) q.push_back(a[47-8*i -: 8]);
    endtask
    // header, sync of n bytes of ones, then reps address copies
    task automatic magic(input logic [47:0] da, input int n, input int reps);
        q = {};
        add(da);
        add(48'h0200_0000_0001);
        repeat (n) q.push_back(8'hFF);
        repeat (reps) add(station_addr);
    endtask
    // gap idle cycles between bytes stands for the slower line speed
    task automatic send(input int gap, input logic crc);
        @(posedge clk) rx_sof <= 1;
        @(posedge clk) rx_sof <= 0;
        foreach (q[i]) begin
            rx_valid <= 1;
            rx_data <= q[i];
            @(posedge clk);
            if (gap > 0) rx_valid <= 0;
            repeat (gap) @(posedge clk);
        end
        rx_valid <= 0;
        rx_eof <= 1;
        rx_crc_ok <= crc;
        @(posedge clk) rx_eof <= 0;
        @(posedge clk);
    endtask
    task automatic clr;
        status_clear <= 1;
        @(posedge clk) status_clear <= 0;
        repeat (12) @(posedge clk);
    endtask
    task automatic expect_st(input logic [2:0] exp);
        chk("status", 8'(exp), 8'(wake_receive_status));
        clr;
    endtask
    // ========================================================
    // scenarios
    task automatic t_magic;
        magic(BCAST_ADDR, 6, 16);
        send(0, 1);
        chk("irq", 8'h01, 8'(wake_irq));
        expect_st(3'h1);
        chk("pulse", 8'h08, pulse_len);
        send(0, 0);
        expect_st(3'h0);
        chk("flags", 8'h01, irq_seen);
        magic(station_addr, 7, 16);
        send(9, 1);
        expect_st(3'h1);
        magic(48'h0200_0000_0002, 6, 16);
        send(0, 1);
        expect_st(3'h0);
        magic(BCAST_ADDR, 5, 16);
        send(0, 1);
        expect_st(3'h0);
    endtask
    // a run broken inside an address copy must not count; a fresh sync
    // right after must, starting again from the first address byte
    task automatic t_break;
        magic(BCAST_ADDR, 6, 15);
        q.push_back(station_addr[47:40]);
        q.push_back(station_addr[39:32]);
        q.push_back(8'h00);
        send(0, 1);
        expect_st(3'h0);
        repeat (6) q.push_back(8'hFF);
        repeat (16) add(station_addr);
        send(0, 1);
        expect_st(3'h1);
    endtask
    task automatic t_password;
        password_enable <= 1;
        magic(BCAST_ADDR, 6, 16);
        send(0, 1);
        expect_st(3'h0);
        add(password);
        send(0, 1);
        expect_st(3'h2);
        q[q.size()-1] = 8'h00;
        send(0, 1);
        expect_st(3'h0);
        password_enable <= 0;
    endtask
    task automatic t_pattern;
        magic_enable <= 0;
        pattern_enable <= 1;
        pattern_mask <= 64'hFFFF_FFFF_FFFF_FFF7;
        q = {};
        for (int i = 0; i < 64; i++) begin
            pattern[8*i +: 8] <= 8'(i);
            q.push_back(i == 3 ? 8'hEE : 8'(i));
        end
        send(0, 1);
        expect_st(3'h4);
        q[5] = 8'hEE;
        send(0, 1);
        expect_st(3'h0);
        q[5] = 8'h05;
        void'(q.pop_back());
        send(0, 1);
        expect_st(3'h0);
        pattern_enable <= 0;
        magic_enable <= 1;
    endtask
    // level mode on another pin, flag masked
    task automatic t_level;
        gpio_pulse_mode <= 0;
        gpio_select <= 2'h1;
        irq_enable <= 0;
        magic(BCAST_ADDR, 6, 16);
        send(0, 1);
        repeat (20) @(posedge clk);
        chk("gpio", 8'h02, 8'(wake_gpio));
        chk("irq", 8'h00, 8'(wake_irq));
        expect_st(3'h1);
        chk("gpio", 8'h00, 8'(wake_gpio));
        // gpio masked: status still records the wake, the pin stays low
        gpio_enable <= 0;
        send(0, 1);
        repeat (4) @(posedge clk);
        chk("gpio", 8'h00, 8'(wake_gpio));
        expect_st(3'h1);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ========================================================
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            err_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 0;
        t_magic;
        t_break;
        t_password;
        t_pattern;
        t_level;
        end_of_test;
    end
endmodule // test_wfd_detector
`default_nettype wire
